//--- hbds_consts.vh
// Shared constants of the half-bridge driver supervisor: clock rate, filter,
// recovery and cross-current timing, driver counts and the synchroniser bit map.
// Assumes it is included by bare name from every design file that needs it.
`ifndef HBDS_CONSTS_VH
`define HBDS_CONSTS_VH

// Logic clock rate in MHz (100 ns period)
`define HBDS_CLK_MHZ 10

// Diagnostic filter time in microseconds and cycles
`define HBDS_FILT_US 32
`define HBDS_FILT_CYC (`HBDS_FILT_US * `HBDS_CLK_MHZ)

// Open-load filter time in microseconds and cycles
`define HBDS_OL_US 1000
`define HBDS_OL_CYC (`HBDS_OL_US * `HBDS_CLK_MHZ)

// Cross-current protection time, typical and ceiling, in microseconds
`define HBDS_XC_US 200
`define HBDS_XC_MAX_US 400
`define HBDS_XC_CYC (`HBDS_XC_US * `HBDS_CLK_MHZ)

// Over-current recovery off times in microseconds for the two duty settings
`define HBDS_REC25_US 96
`define HBDS_REC12_US 240
`define HBDS_REC25_CYC (`HBDS_REC25_US * `HBDS_CLK_MHZ)
`define HBDS_REC12_CYC (`HBDS_REC12_US * `HBDS_CLK_MHZ)

// Counter widths
`define HBDS_CNT_W 12
`define HBDS_OL_CNT_W 14

// Structure
`define HBDS_NUM_DRV 8
`define HBDS_NUM_OUT 5
`define HBDS_NUM_BRIDGE 3
`define HBDS_CM_SEL_W 3

// Bit positions in the synchronised input vector
`define HBDS_SY_CSN 0
`define HBDS_SY_PWM 1
`define HBDS_SY_EN 2
`define HBDS_SY_VCCLOW 3
`define HBDS_SY_TSD 4
`define HBDS_SY_TW 5
`define HBDS_SY_UV 6
`define HBDS_SY_OV 7
`define HBDS_SY_OL 8
`define HBDS_SY_OC 16
`define HBDS_SY_W 24
`define HBDS_SY_INIT 24'h000001

`endif

//--- hbds_sync.v
// Three-stage synchroniser for a vector of pins from outside the clock domain.
// A bit changes only once the second and third stages agree on its new level.
`timescale 1ns/1ns
module hbds_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire clk,
   input wire reset,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;

   // First stage is read only by the second; the filter compares stages two and three
   always @(posedge clk) begin
      if (reset) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         q <= INIT;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q <= (s2_q & s3_q) | (q & (s2_q ^ s3_q));
      end
   end
endmodule

//--- hbds_filt.v
// Persistence filter: the output rises once the condition has held for LIMIT
// consecutive cycles and falls as soon as the condition goes away.
// Assumes cond is already synchronous to clk.
`timescale 1ns/1ns
module hbds_filt #(
   parameter CW = 12,
   parameter LIMIT = 320
) (
   input wire clk,
   input wire clear,
   input wire cond,
   output reg qual
);
   localparam integer LIM_I = LIMIT - 1;
   localparam [CW-1:0] LIM_M1 = LIM_I[CW-1:0];
   reg [CW-1:0] cnt_q;

   // Counter restarts whenever the condition drops, so short glitches never qualify
   always @(posedge clk) begin
      if (clear || !cond) begin
         cnt_q <= {CW{1'b0}};
         qual <= 1'b0;
      end else if (cnt_q == LIM_M1) begin
         qual <= 1'b1; // [R24]
      end else begin
         cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
   end
endmodule

//--- hbds_top.v
// Control and protection logic of a three half-bridge, two source-switch driver.
// Assumes the serial frame decoder delivers the input register bits as levels,
// and that all condition inputs come from analog comparators outside the clock.
//
// What this block does, and what its host must do
// [R01] Host waits after enable before first frame
// [R02] Host keeps chip select high between frames
// [R03] Reset initialises all control and status logic
// [R04] Logic supply loss disables outputs, clears status
// [R05] Enable low: standby, clear all, outputs off
// [R06] Enable high: active, charge pump and supervision
// [R07] Diagnostics need 32 us persistence before flagging
// [R08] Open-load and warning only set flags
// [R09] Overload stops its driver, shutdown stops all
// [R10] Without recovery, overload latches until host clears
// [R11] With recovery, driver restarts at 12/25% duty
// [R12] Overvoltage disables outputs and the charge pump
// [R13] Undervoltage disables the output stages
// [R14] Supply return resumes unless recovery disable set
// [R15] Temperature warning sets a readable flag
// [R16] Thermal shutdown holds until cool and cleared
// [R17] Open-load flag after 1 ms low current
// [R18] Three select bits route one output to monitor
// [R19] PWM-enabled drivers follow PWM AND control bit
// [R20] Opposite switch waits the cross-current time
// [R21] After delay: fast turn-off, slew-limited turn-on
// [R22] Cross-current delay about 200 us, under 400
// [R23] Clear bit wipes status at chip select rise
// [R24] Timing counted in clock cycles, restarts on drop
// [R25] Invalid monitor select leaves monitor disconnected
`timescale 1ns/1ns
`include "hbds_consts.vh"
module hbds_top #(
   parameter OL_CYC = `HBDS_OL_CYC
) (
   input wire clk,
   input wire reset,
   input wire enable_in,
   input wire vcc_low,
   input wire chip_select_n,
   input wire status_clear_bit,
   input wire pwm_in,
   input wire [`HBDS_NUM_DRV-1:0] drive_bits,
   input wire [`HBDS_NUM_DRV-1:0] pwm_en_bits,
   input wire [`HBDS_NUM_DRV-1:0] oc_recovery_bits,
   input wire recovery_duty_25,
   input wire supply_recovery_disable,
   input wire [`HBDS_CM_SEL_W-1:0] cm_select,
   input wire [`HBDS_NUM_DRV-1:0] overload_cond,
   input wire [`HBDS_NUM_DRV-1:0] open_load_cond,
   input wire overvoltage_cond,
   input wire undervoltage_cond,
   input wire temp_warning_cond,
   input wire thermal_shutdown_cond,
   output wire [`HBDS_NUM_DRV-1:0] drv_on,
   output wire [`HBDS_NUM_DRV-1:0] drv_fast_off,
   output reg charge_pump_en,
   output reg active_mode,
   output reg serial_out_enable,
   output reg [`HBDS_NUM_OUT-1:0] cm_route,
   output reg [`HBDS_NUM_DRV-1:0] oc_status,
   output reg [`HBDS_NUM_DRV-1:0] ol_status,
   output reg ov_status,
   output reg uv_status,
   output reg tw_status,
   output reg tsd_status,
   output reg fault
);
   localparam ND = `HBDS_NUM_DRV;
   localparam CW = `HBDS_CNT_W;
   // Counts arrive 32 bits wide; cut to the counter
   localparam integer XC_I = `HBDS_XC_CYC;
   localparam integer REC25_I = `HBDS_REC25_CYC;
   localparam integer REC12_I = `HBDS_REC12_CYC;
   localparam [CW-1:0] XC_CYC = XC_I[CW-1:0];
   localparam [CW-1:0] REC25_CYC = REC25_I[CW-1:0];
   localparam [CW-1:0] REC12_CYC = REC12_I[CW-1:0];
   localparam [CW-1:0] CNT_ONE = 12'h001;

   wire [`HBDS_SY_W-1:0] sy_raw;
   wire [`HBDS_SY_W-1:0] sy;
   wire cs_n_s;
   wire pwm_s;
   wire en_s;
   wire vcc_low_s;
   wire clr;
   wire sclr;
   wire [ND-1:0] oc_qual;
   wire [ND-1:0] ol_qual;
   wire [3:0] env_qual;
   wire tsd_qual;
   wire tw_qual;
   wire uv_qual;
   wire ov_qual;
   wire supply_block;
   wire [ND-1:0] oc_block;
   wire [ND-1:0] want;
   wire [ND-1:0] pwm_gate;
   reg cs_prev_q;
   reg [ND-1:0] oc_prev_q;
   reg [CW-1:0] rec_q [0:ND-1];
   reg [`HBDS_NUM_OUT-1:0] cm_route_d;

   // All pins and comparator outputs cross into the clock domain together
   assign sy_raw = {overload_cond, open_load_cond, overvoltage_cond, undervoltage_cond,
                    temp_warning_cond, thermal_shutdown_cond, vcc_low, enable_in,
                    pwm_in, chip_select_n};
   // A change counts once two late stages agree,
   // so an edge near the clock makes no spike

   hbds_sync #(
      .W(`HBDS_SY_W),
      .INIT(`HBDS_SY_INIT)
   ) u_sync (
      .clk(clk),
      .reset(reset),
      .d(sy_raw),
      .q(sy)
   );

   assign cs_n_s = sy[`HBDS_SY_CSN];
   assign pwm_s = sy[`HBDS_SY_PWM];
   assign en_s = sy[`HBDS_SY_EN];
   assign vcc_low_s = sy[`HBDS_SY_VCCLOW];

   // Power-on reset, logic supply loss and standby all wipe the latched state
   assign clr = reset | vcc_low_s | ~en_s; // [R03] [R04] [R05]
   // The clock runs in standby too, so a
   // clocked wipe is enough

   // Status clear request takes effect when the frame ends, on chip select rising
   assign sclr = cs_n_s & ~cs_prev_q & status_clear_bit; // [R23]
   // Clear bit must stand until the synced rise

   // Resets to idle high, so no false rise
   always @(posedge clk) begin
      if (reset) begin
         cs_prev_q <= 1'b1;
      end else begin
         cs_prev_q <= cs_n_s;
      end
   end

   // Overload filters only watch a driver that is switched on
   // Limitation: no open-load check while off
   genvar gi;
   generate
      for (gi = 0; gi < ND; gi = gi + 1) begin : g_drv_filt
         hbds_filt #(
            .CW(CW),
            .LIMIT(`HBDS_FILT_CYC)
         ) u_oc (
            .clk(clk),
            .clear(clr),
            .cond(sy[`HBDS_SY_OC + gi] & drv_on[gi]),
            .qual(oc_qual[gi])
         ); // [R07]
         hbds_filt #(
            .CW(`HBDS_OL_CNT_W),
            .LIMIT(OL_CYC)
         ) u_ol (
            .clk(clk),
            .clear(clr),
            .cond(sy[`HBDS_SY_OL + gi] & drv_on[gi]),
            .qual(ol_qual[gi])
         ); // [R17]
      end
      // Supply and temperature comparators share the 32 us filter
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_env_filt
         hbds_filt #(
            .CW(CW),
            .LIMIT(`HBDS_FILT_CYC)
         ) u_env (
            .clk(clk),
            .clear(clr),
            .cond(sy[`HBDS_SY_TSD + gi]),
            .qual(env_qual[gi])
         ); // [R07]
      end
   endgenerate

   // Same order as the synchroniser bit map
   assign tsd_qual = env_qual[0];
   assign tw_qual = env_qual[1];
   assign uv_qual = env_qual[2];
   assign ov_qual = env_qual[3];

   // Status flags: a new event in the clearing cycle wins over the clear
   // fault lags the flags by one cycle
   always @(posedge clk) begin
      if (clr) begin
         oc_status <= {ND{1'b0}};
         ol_status <= {ND{1'b0}};
         ov_status <= 1'b0;
         uv_status <= 1'b0;
         tw_status <= 1'b0;
         tsd_status <= 1'b0;
         fault <= 1'b0;
      end else begin
         oc_status <= oc_qual | (oc_status & {ND{~sclr}}); // [R23]
         ol_status <= ol_qual | (ol_status & {ND{~sclr}}); // [R08] [R17]
         ov_status <= ov_qual | (ov_status & ~sclr);
         uv_status <= uv_qual | (uv_status & ~sclr);
         tw_status <= tw_qual | (tw_status & ~sclr); // [R15] [R08]
         tsd_status <= tsd_qual | (tsd_status & ~sclr); // [R16]
         fault <= (|oc_status) | (|ol_status) | ov_status | uv_status | tw_status | tsd_status;
      end
   end

   // Recovery timers: a fresh overload on a driver with recovery set holds it off
   // for the chosen off time, then lets it retry; the filter time is the on phase
   // A retry into the same overload starts anew
   generate
      for (gi = 0; gi < ND; gi = gi + 1) begin : g_rec
         always @(posedge clk) begin
            if (clr) begin
               rec_q[gi] <= {CW{1'b0}};
            end else if (oc_qual[gi] && !oc_prev_q[gi] && oc_recovery_bits[gi]) begin
               rec_q[gi] <= recovery_duty_25 ? REC25_CYC : REC12_CYC; // [R11]
            end else if (rec_q[gi] != {CW{1'b0}}) begin
               rec_q[gi] <= rec_q[gi] - CNT_ONE; // [R24]
            end
         end
         // Only this driver is blocked; latched until cleared when recovery is off
         assign oc_block[gi] = (rec_q[gi] != {CW{1'b0}}) | oc_qual[gi] |
                               (oc_status[gi] & ~oc_recovery_bits[gi]); // [R09] [R10]
      end
   endgenerate

   always @(posedge clk) begin
      if (clr) begin
         oc_prev_q <= {ND{1'b0}};
      end else begin
         oc_prev_q <= oc_qual;
      end
   end

   // Supply faults block while present; with recovery disabled the flags keep blocking
   // Otherwise the flags only inform the host
   assign supply_block = ov_qual | uv_qual |
                         (supply_recovery_disable & (ov_status | uv_status)); // [R12] [R13] [R14]

   // PWM gating applies only to drivers whose PWM enable bit is set
   // The pin is synchronised: four cycles late
   assign pwm_gate = pwm_en_bits & {ND{~pwm_s}};

   // Requested state of each driver after gating and protection
   assign want = drive_bits & ~pwm_gate & ~oc_block &
                 {ND{active_mode & ~supply_block & ~tsd_status & ~tsd_qual}}; // [R19] [R09] [R16]

   // Half bridges: even index is the source switch, odd index the sink switch.
   // A switch turns off at once; the counter then keeps both off, the outgoing
   // one still in its slew-limited turn-off, until the delay runs out.
   // Both switches requested: neither turns on.
   // The delay also holds the same switch off.
   generate
      for (gi = 0; gi < `HBDS_NUM_BRIDGE; gi = gi + 1) begin : g_bridge
         reg src_q;
         reg snk_q;
         reg [CW-1:0] xc_q;
         always @(posedge clk) begin
            if (clr) begin
               src_q <= 1'b0;
               snk_q <= 1'b0;
               xc_q <= {CW{1'b0}};
            end else if (src_q && !want[2*gi]) begin
               src_q <= 1'b0;
               xc_q <= XC_CYC; // [R20] [R22]
            end else if (snk_q && !want[2*gi+1]) begin
               snk_q <= 1'b0;
               xc_q <= XC_CYC; // [R20] [R22]
            end else if (xc_q != {CW{1'b0}}) begin
               xc_q <= xc_q - CNT_ONE; // [R24]
            end else if (want[2*gi] && !want[2*gi+1] && !snk_q) begin
               src_q <= 1'b1; // [R21]
            end else if (want[2*gi+1] && !want[2*gi] && !src_q) begin
               snk_q <= 1'b1; // [R21]
            end
         end
         assign drv_on[2*gi] = src_q;
         assign drv_on[2*gi+1] = snk_q;
         // Fast turn-off engages only once the protection time has expired
         assign drv_fast_off[2*gi] = ~src_q & (xc_q == {CW{1'b0}}); // [R21]
         assign drv_fast_off[2*gi+1] = ~snk_q & (xc_q == {CW{1'b0}}); // [R21]
      end
      // Stand-alone source switches have no partner to protect against
      // so they follow the request one cycle late
      for (gi = 2 * `HBDS_NUM_BRIDGE; gi < ND; gi = gi + 1) begin : g_single
         reg on_q;
         always @(posedge clk) begin
            if (clr) begin
               on_q <= 1'b0;
            end else begin
               on_q <= want[gi];
            end
         end
         assign drv_on[gi] = on_q;
         assign drv_fast_off[gi] = ~on_q;
      end
   endgenerate

   // Mode and supply outputs; charge pump stops on overvoltage
   // The frame decoder outside drives the data pin
   always @(posedge clk) begin
      if (clr) begin
         active_mode <= 1'b0;
         charge_pump_en <= 1'b0;
         serial_out_enable <= 1'b0;
      end else begin
         active_mode <= 1'b1; // [R06]
         charge_pump_en <= ~ov_qual; // [R06] [R12]
         serial_out_enable <= ~cs_n_s; // [R05]
      end
   end

   // Monitor routing: codes past the last output leave the monitor open
   // Registered so the route never glitches
   always @* begin
      cm_route_d = 5'h00;
      case (cm_select)
         3'h0: cm_route_d = 5'h01; // [R18]
         3'h1: cm_route_d = 5'h02;
         3'h2: cm_route_d = 5'h04;
         3'h3: cm_route_d = 5'h08;
         3'h4: cm_route_d = 5'h10;
         default: cm_route_d = 5'h00; // [R25]
      endcase
   end

   always @(posedge clk) begin
      if (clr) begin
         cm_route <= 5'h00;
      end else begin
         cm_route <= cm_route_d;
      end
   end

   // The host timing after enable and between frames is its own duty; the
   // synchroniser latency stays well inside those gaps ([R01] [R02])
   // A host that breaks them may lose a frame,
   // but the protection logic still holds
endmodule

//--- hbds_monitor.sv
// Port checker of the half-bridge driver supervisor.
// Assumes it is bound to hbds_top and watches only that module's ports.
`timescale 1ns/1ns
module hbds_monitor (
   input wire clk,
   input wire reset,
   input wire [2:0] cm_select,
   input wire [7:0] oc_recovery_bits,
   input wire [7:0] drv_on,
   input wire [7:0] drv_fast_off,
   input wire charge_pump_en,
   input wire active_mode,
   input wire [4:0] cm_route,
   input wire [7:0] oc_status,
   input wire [7:0] ol_status,
   input wire ov_status,
   input wire uv_status,
   input wire tw_status,
   input wire tsd_status,
   input wire fault
);
   reg [11:0] gap_q;
   default clocking mon_cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // Cycles since bridge 0 source was on; starts saturated so a first sink turn-on is not judged
   always @(posedge clk) begin
      if (reset)
         gap_q <= 12'hFFF;
      else if (drv_on[0])
         gap_q <= 12'h000;
      else if (gap_q != 12'hFFF)
         gap_q <= gap_q + 12'h001;
   end
   sequence sink_start;
      $rose(drv_on[1]) ##0 (gap_q != 12'hFFF);
   endsequence
   reset_clear_a: assert property (disable iff (1'b0) reset |=> drv_on == 8'h00 && !active_mode && !fault)
      else $error("outputs not cleared by reset");
   standby_off_a: assert property (!active_mode && !$past(active_mode) |-> drv_on == 8'h00 && !charge_pump_en)
      else $error("driver on outside active mode");
   fault_or_a: assert property (active_mode && $past(active_mode) |->
      fault == $past(|{oc_status, ol_status, ov_status, uv_status, tw_status, tsd_status}))
      else $error("fault is not the OR of the flags");
   cm_map_a: assert property (active_mode && $past(active_mode, 2) && cm_select < 3'h5 && $stable(cm_select)
      |-> cm_route == (5'h01 << cm_select))
      else $error("monitor routes the wrong output");
   cm_bad_a: assert property ((cm_select > 3'h4) [*2] |-> cm_route == 5'h00)
      else $error("monitor connected for an invalid select");
   bridge_excl_a: assert property (!(drv_on[0] && drv_on[1]) && !(drv_on[2] && drv_on[3]) && !(drv_on[4] && drv_on[5]))
      else $error("both switches of a bridge on");
   fast_off_a: assert property ((drv_on & drv_fast_off) == 8'h00)
      else $error("fast turn-off while driver on");
   xc_delay_a: assert property (sink_start |-> gap_q >= 12'h7D0 && gap_q <= 12'hFA0)
      else $error("cross-current delay out of range");
   oc_hold_a: assert property ((oc_status & $past(oc_status) & drv_on &
      ~(oc_recovery_bits | $past(oc_recovery_bits))) == 8'h00)
      else $error("overloaded driver on without recovery");
   tsd_off_a: assert property (tsd_status && $past(tsd_status) |-> drv_on == 8'h00)
      else $error("driver on during thermal shutdown");
endmodule
bind hbds_top hbds_monitor mon_u (.clk(clk), .reset(reset), .cm_select(cm_select),
   .oc_recovery_bits(oc_recovery_bits), .drv_on(drv_on), .drv_fast_off(drv_fast_off),
   .charge_pump_en(charge_pump_en), .active_mode(active_mode), .cm_route(cm_route), .oc_status(oc_status),
   .ol_status(ol_status), .ov_status(ov_status), .uv_status(uv_status), .tw_status(tw_status),
   .tsd_status(tsd_status), .fault(fault));

//--- hbds_host_model.sv
// Serial host stand-in: frames chip select and the clear bit of the frame.
// Assumes the bench drives enable_in and calls frame() after a clock edge.
`timescale 1ns/1ns
module hbds_host_model (
   input wire clk,
   input wire enable_in,
   output reg chip_select_n,
   output reg status_clear_bit
);
   localparam integer EN_WAIT = 500;
   localparam integer GAP = 40;
   integer en_cnt = 0;
   integer gap_cnt = 40;
   initial begin
      chip_select_n = 1'b1;
      status_clear_bit = 1'b0;
   end
   // Time since enable rose and since the last frame ended
   always @(posedge clk) begin
      en_cnt <= enable_in ? en_cnt + 1 : 0;
      gap_cnt <= chip_select_n ? gap_cnt + 1 : 0;
   end
   // One frame of sixteen 800 ns link periods; the clear bit is held past the synchroniser
   task frame(input reg clr);
      begin
         while (en_cnt < EN_WAIT || gap_cnt < GAP) @(posedge clk);
         chip_select_n <= 1'b0;
         repeat (128) @(posedge clk);
         status_clear_bit <= clr;
         @(posedge clk);
         chip_select_n <= 1'b1;
         repeat (8) @(posedge clk);
         status_clear_bit <= 1'b0;
      end
   endtask
endmodule

//--- testbench.sv
// Self-checking bench of the supervisor with a serial host model.
// Assumes open-load filter shortened to 50 cycles; waits carry margin over the filter times.
`timescale 1ns/1ns
module testbench;
   reg clk = 1'b0, reset = 1'b1, enable_in = 1'b0, vcc_low = 1'b0, pwm_in = 1'b0, recovery_duty_25 = 1'b0;
   reg supply_recovery_disable = 1'b0, overvoltage_cond = 1'b0, undervoltage_cond = 1'b0;
   reg temp_warning_cond = 1'b0, thermal_shutdown_cond = 1'b0;
   reg [7:0] drive_bits = 8'h00, pwm_en_bits = 8'h00, oc_recovery_bits = 8'h00;
   reg [7:0] overload_cond = 8'h00, open_load_cond = 8'h00;
   reg [2:0] cm_select = 3'h0;
   wire chip_select_n, status_clear_bit, charge_pump_en, active_mode, serial_out_enable;
   wire ov_status, uv_status, tw_status, tsd_status, fault;
   wire [7:0] drv_on, drv_fast_off, oc_status, ol_status;
   wire [4:0] cm_route;
   integer fail_count = 0;
   integer n_compared = 0;
   integer i;
   hbds_top #(.OL_CYC(50)) dut_u (.clk(clk), .reset(reset), .enable_in(enable_in), .vcc_low(vcc_low),
      .chip_select_n(chip_select_n), .status_clear_bit(status_clear_bit), .pwm_in(pwm_in), .drive_bits(drive_bits),
      .pwm_en_bits(pwm_en_bits), .oc_recovery_bits(oc_recovery_bits), .recovery_duty_25(recovery_duty_25),
      .supply_recovery_disable(supply_recovery_disable), .cm_select(cm_select), .overload_cond(overload_cond),
      .open_load_cond(open_load_cond), .overvoltage_cond(overvoltage_cond), .undervoltage_cond(undervoltage_cond),
      .temp_warning_cond(temp_warning_cond), .thermal_shutdown_cond(thermal_shutdown_cond), .drv_on(drv_on),
      .drv_fast_off(drv_fast_off), .charge_pump_en(charge_pump_en), .active_mode(active_mode),
      .serial_out_enable(serial_out_enable), .cm_route(cm_route), .oc_status(oc_status), .ol_status(ol_status),
      .ov_status(ov_status), .uv_status(uv_status), .tw_status(tw_status), .tsd_status(tsd_status), .fault(fault));
   hbds_host_model host_u (.clk(clk), .enable_in(enable_in), .chip_select_n(chip_select_n),
      .status_clear_bit(status_clear_bit));
   // 100 ns clock
   initial begin
      forever #50 clk = ~clk;
   end
   task tick(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task chk(input string what, input [7:0] exp, input [7:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task close_out;
      begin
         $display("compared %0d mismatches %0d", n_compared, fail_count);
         if (fail_count == 0 && n_compared > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // Start up into active mode with the two source-only outputs on
   task t_start;
      begin
         chk("drv_on", 8'h00, drv_on);
         enable_in <= 1'b1;
         tick(10);
         chk("active", 8'h01, 8'(active_mode));
         chk("pump", 8'h01, 8'(charge_pump_en));
         drive_bits <= 8'hC0;
         tick(2100);
         chk("drv_on", 8'hC0, drv_on);
      end
   endtask
   // Short overload ignored, long one latches until the host clears it
   task t_overload;
      begin
         overload_cond <= 8'h40;
         tick(200);
         overload_cond <= 8'h00;
         tick(400);
         chk("oc_status", 8'h00, oc_status);
         overload_cond <= 8'h40;
         tick(400);
         chk("oc_status", 8'h40, oc_status);
         chk("drv_on", 8'h80, drv_on);
         chk("fault", 8'h01, 8'(fault));
         overload_cond <= 8'h00;
         tick(100);
         chk("drv_on", 8'h80, drv_on);
         host_u.frame(1'b1);
         tick(2100);
         chk("oc_status", 8'h00, oc_status);
         chk("drv_on", 8'hC0, drv_on);
      end
   endtask
   // Both recovery duty settings restart the driver unattended
   task t_recovery;
      begin
         oc_recovery_bits <= 8'h80;
         for (i = 0; i < 2; i = i + 1) begin
            recovery_duty_25 <= i[0];
            overload_cond <= 8'h80;
            tick(400);
            chk("drv_on", 8'h40, drv_on);
            overload_cond <= 8'h00;
            tick(4800);
            chk("drv_on", 8'hC0, drv_on);
         end
         oc_recovery_bits <= 8'h00;
         host_u.frame(1'b1);
      end
   endtask
   // Information flags leave drivers alone
   task t_info;
      begin
         open_load_cond <= 8'h80;
         temp_warning_cond <= 1'b1;
         tick(400);
         chk("ol_status", 8'h80, ol_status);
         chk("tw_status", 8'h01, 8'(tw_status));
         chk("drv_on", 8'hC0, drv_on);
         open_load_cond <= 8'h00;
         temp_warning_cond <= 1'b0;
         fork
            host_u.frame(1'b1);
            begin
               tick(64);
               chk("so_en", 8'h01, 8'(serial_out_enable));
            end
         join
         chk("so_en", 8'h00, 8'(serial_out_enable));
         tick(10);
         chk("ol_status", 8'h00, ol_status);
      end
   endtask
   // Shutdown holds everything off until cool and cleared
   task t_tsd;
      begin
         thermal_shutdown_cond <= 1'b1;
         tick(400);
         chk("tsd_status", 8'h01, 8'(tsd_status));
         chk("drv_on", 8'h00, drv_on);
         thermal_shutdown_cond <= 1'b0;
         tick(100);
         chk("drv_on", 8'h00, drv_on);
         host_u.frame(1'b1);
         tick(2100);
         chk("drv_on", 8'hC0, drv_on);
      end
   endtask
   // Overvoltage resumes by itself, undervoltage with recovery disable waits for a clear
   task t_supply;
      begin
         overvoltage_cond <= 1'b1;
         tick(400);
         chk("drv_on", 8'h00, drv_on);
         chk("pump", 8'h00, 8'(charge_pump_en));
         overvoltage_cond <= 1'b0;
         tick(2100);
         chk("drv_on", 8'hC0, drv_on);
         supply_recovery_disable <= 1'b1;
         undervoltage_cond <= 1'b1;
         tick(400);
         chk("uv_status", 8'h01, 8'(uv_status));
         chk("drv_on", 8'h00, drv_on);
         undervoltage_cond <= 1'b0;
         tick(2100);
         chk("drv_on", 8'h00, drv_on);
         host_u.frame(1'b1);
         tick(2100);
         chk("drv_on", 8'hC0, drv_on);
         supply_recovery_disable <= 1'b0;
      end
   endtask
   // Bridge 0 source to sink swap, then PWM gating and monitor select codes
   task t_bridge_pwm_cm;
      begin
         drive_bits <= 8'hC1;
         tick(2100);
         drive_bits <= 8'hC2;
         tick(1900);
         chk("drv_on", 8'hC0, drv_on);
         chk("fast_off0", 8'h00, 8'(drv_fast_off[0]));
         tick(200);
         chk("drv_on", 8'hC2, drv_on);
         chk("fast_off0", 8'h01, 8'(drv_fast_off[0]));
         drive_bits <= 8'hC0;
         pwm_en_bits <= 8'h40;
         tick(10);
         chk("drv_on", 8'h80, drv_on);
         pwm_in <= 1'b1;
         tick(2100);
         chk("drv_on", 8'hC0, drv_on);
         pwm_in <= 1'b0;
         tick(10);
         chk("drv_on", 8'h80, drv_on);
         pwm_en_bits <= 8'h00;
         tick(2);
         chk("drv_on", 8'hC0, drv_on);
         for (i = 0; i < 8; i = i + 1) begin
            cm_select <= i[2:0];
            tick(4);
            chk("cm_route", (i < 5) ? (8'h01 << i) : 8'h00, 8'(cm_route));
         end
      end
   endtask
   // Standby and logic supply loss wipe outputs and flags
   task t_standby;
      begin
         temp_warning_cond <= 1'b1;
         tick(400);
         enable_in <= 1'b0;
         tick(10);
         chk("drv_on", 8'h00, drv_on);
         chk("tw_status", 8'h00, 8'(tw_status));
         chk("active", 8'h00, 8'(active_mode));
         enable_in <= 1'b1;
         tick(2100);
         vcc_low <= 1'b1;
         tick(10);
         chk("drv_on", 8'h00, drv_on);
         chk("tw_status", 8'h00, 8'(tw_status));
         vcc_low <= 1'b0;
         reset <= 1'b1;
         tick(3);
         reset <= 1'b0;
         tick(2);
         chk("active", 8'h00, 8'(active_mode));
         tick(2100);
         chk("drv_on", 8'hC0, drv_on);
      end
   endtask
   // Main sequence
   initial begin
      tick(3);
      reset <= 1'b0;
      tick(2);
      t_start();
      t_overload();
      t_recovery();
      t_info();
      t_tsd();
      t_supply();
      t_bridge_pwm_cm();
      t_standby();
      close_out();
   end
   // Watchdog well beyond the expected run of about 40k cycles
   initial begin
      #8000000;
      fail_count = fail_count + 1;
      close_out();
   end
endmodule
